//--- rtl/hdt_transfer_ctrl.sv
// microprocessor-side dma transfer control: setup, byte count, event flags
`timescale 1ns/1ps
module hdt_transfer_ctrl (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic data_write,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  input wire logic dma_ack,
  input wire logic end_of_transfer,
  input wire logic pio_done,
  input wire logic frame_iso_event,
  input wire logic async_list_event,
  input wire logic operational_event,
  input wire logic host_asleep_event,
  input wire logic clock_ready_event,
  input wire logic irq_master_enable,
  output logic dma_request_out,
  output logic list_buffer_pick,
  output logic transfer_direction,
  output logic buffer_status_update,
  output logic irq_out
);
  logic [7:0] cmd_latched;
  logic [15:0] dma_setup;
  logic [15:0] transfer_byte_count;
  logic [3:0] beat_count;
  hdt_pkg::hdt_state_e state;
  hdt_pkg::hdt_state_e next_state;
  logic [15:0] counter_remaining;
  logic counter_last;
  logic [6:0] cpu_event_flags;
  logic [6:0] event_enable_reg;

  // number of beats in one request for a burst code
  function automatic logic [3:0] burst_beats(input logic [1:0] code);
    unique case (code)
      hdt_pkg::BURST_FOUR: burst_beats = 4'h4;
      hdt_pkg::BURST_EIGHT: burst_beats = 4'h8;
      default: burst_beats = 4'h1;
    endcase
  endfunction

  // setup field views
  wire logic [1:0] burst_length_sel = dma_setup[hdt_pkg::SETUP_BURST_LO +: 2];
  wire logic transfer_run = dma_setup[hdt_pkg::SETUP_RUN_BIT];
  wire logic byte_counter_use = dma_setup[hdt_pkg::SETUP_USE_BIT];

  // data-phase write decode against the latched command
  wire logic wr_setup = data_write && (cmd_latched == hdt_pkg::CMD_SETUP_WR);
  wire logic wr_count = data_write && (cmd_latched == hdt_pkg::CMD_COUNT_WR);
  wire logic wr_flags = data_write && (cmd_latched == hdt_pkg::CMD_FLAGS_WR);
  wire logic wr_enable = data_write && (cmd_latched == hdt_pkg::CMD_ENABLE_WR);
  // reserved setup bits dropped on write
  wire logic [15:0] setup_written = data_in & hdt_pkg::SETUP_MASK;
  wire logic run_start = wr_setup && setup_written[hdt_pkg::SETUP_RUN_BIT];

  // transfer progress
  wire logic in_req = (state == hdt_pkg::HDT_REQ);
  wire logic beat = in_req && dma_ack;
  wire logic internal_end = beat && byte_counter_use && counter_last;
  wire logic external_end = end_of_transfer && (state != hdt_pkg::HDT_IDLE);
  wire logic transfer_end = internal_end || external_end;
  wire logic burst_full = beat && ((beat_count + 4'h1) >= burst_beats(burst_length_sel));
  // counter mode needs a non-zero count
  wire logic count_ok = !byte_counter_use || (counter_remaining != 16'h0000);
  wire logic may_start = transfer_run && (burst_length_sel != hdt_pkg::BURST_RSVD) && count_ok;

  // any end of transfer sets the done flag
  wire logic [6:0] set_events = {clock_ready_event, host_asleep_event, operational_event,
    1'b0, (transfer_end || pio_done), async_list_event, frame_iso_event};

  // read data select for a read command; unknown codes read zero
  wire logic [15:0] read_value =
    (cmd_code == hdt_pkg::CMD_SETUP_RD) ? dma_setup :
    (cmd_code == hdt_pkg::CMD_COUNT_RD) ? transfer_byte_count :
    (cmd_code == hdt_pkg::CMD_FLAGS_RD) ? {9'h000, cpu_event_flags} :
    (cmd_code == hdt_pkg::CMD_ENABLE_RD) ? {9'h000, event_enable_reg} : 16'h0000;

  // the counter: loaded at run start
  hdt_byte_counter u_counter (
    .mclk(mclk),
    .srst(srst),
    // copy only with counter use set
    .load(run_start && setup_written[hdt_pkg::SETUP_USE_BIT]),
    .load_value(transfer_byte_count),
    .beat(beat),
    .remaining(counter_remaining),
    .last_beat(counter_last)
  );

  // flags and interrupt pin
  hdt_event_flags u_flags (
    .mclk(mclk),
    .srst(srst),
    .set_events(set_events),
    .flags_write(wr_flags),
    .enable_write(wr_enable),
    .write_data(data_in[6:0]),
    .irq_master_enable(irq_master_enable),
    .flags(cpu_event_flags),
    .enables(event_enable_reg),
    .irq_out(irq_out)
  );

  // command latch and read data; reading never disturbs flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd_latched <= 8'h00;
      data_out <= 16'h0000;
    end else if (cmd_write) begin
      cmd_latched <= cmd_code;
      data_out <= read_value;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      transfer_byte_count <= hdt_pkg::COUNT_RESET;
    end else if (wr_count) begin
      transfer_byte_count <= data_in;
    end
  end

  // setup register, reserved bits held at zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      dma_setup <= hdt_pkg::SETUP_RESET;
    end else if (wr_setup) begin
      dma_setup <= setup_written;
    end else if (transfer_end) begin
      dma_setup[hdt_pkg::SETUP_RUN_BIT] <= 1'b0;
    end
  end

  // next state of the request machine
  always_comb begin
    next_state = state;
    unique case (state)
      hdt_pkg::HDT_IDLE: begin
        if (may_start && !wr_setup) begin
          next_state = hdt_pkg::HDT_REQ;
        end
      end
      hdt_pkg::HDT_REQ: begin
        if (!transfer_run || transfer_end || wr_setup) begin
          next_state = hdt_pkg::HDT_IDLE;
        end else if (burst_full) begin
          next_state = hdt_pkg::HDT_GAP;
        end
      end
      hdt_pkg::HDT_GAP: begin
        if (!transfer_run || transfer_end || wr_setup) begin
          next_state = hdt_pkg::HDT_IDLE;
        end else begin
          next_state = hdt_pkg::HDT_REQ;
        end
      end
      default: next_state = hdt_pkg::HDT_IDLE;
    endcase
  end

  // state and beats within the current burst
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= hdt_pkg::HDT_IDLE;
      beat_count <= 4'h0;
    end else begin
      state <= next_state;
      if (next_state != hdt_pkg::HDT_REQ) begin
        beat_count <= 4'h0;
      end else if (beat) begin
        beat_count <= beat_count + 4'h1;
      end
    end
  end

  // registered outputs toward the dma controller and buffer logic
  always_ff @(posedge mclk) begin
    if (srst) begin
      list_buffer_pick <= 1'b0;
      transfer_direction <= 1'b0;
      buffer_status_update <= 1'b0;
    end else begin
      list_buffer_pick <= dma_setup[hdt_pkg::SETUP_PICK_BIT];
      transfer_direction <= dma_setup[hdt_pkg::SETUP_DIR_BIT];
      buffer_status_update <= internal_end;
    end
  end

  // request level while the machine is asking
  assign dma_request_out = in_req;

  AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (srst)
    (dma_setup & ~hdt_pkg::SETUP_MASK) == 16'h0000)
    else $error("reserved setup bits not zero");
  AST_RSVD_BURST_IDLE: assert property (@(posedge mclk) disable iff (srst)
    (burst_length_sel == 2'h3 && state == hdt_pkg::HDT_IDLE) |=> !dma_request_out)
    else $error("reserved burst code started a transfer");
  AST_BURST_GAP: assert property (@(posedge mclk) disable iff (srst)
    (burst_length_sel == 2'h1 && beat && beat_count == 4'h3 && !transfer_end && !wr_setup)
      |=> !dma_request_out ##1 dma_request_out)
    else $error("four-beat burst did not pause after four beats");
  AST_STOP: assert property (@(posedge mclk) disable iff (srst)
    (wr_setup && !setup_written[4]) |=> !transfer_run && !dma_request_out)
    else $error("run write of zero did not stop the transfer");
  AST_SELF_CLEAR: assert property (@(posedge mclk) disable iff (srst)
    (transfer_end && !wr_setup) |=> !transfer_run ##1 !dma_request_out)
    else $error("run bit not cleared at end of transfer");
  AST_ZERO_COUNT: assert property (@(posedge mclk) disable iff (srst)
    (byte_counter_use && counter_remaining == 16'h0000 && state == hdt_pkg::HDT_IDLE)
      |=> !dma_request_out)
    else $error("request raised with an empty counter");
  AST_COUNT_LOAD: assert property (@(posedge mclk) disable iff (srst)
    (run_start && !data_in[2] && !beat) |=> counter_remaining == $past(counter_remaining))
    else $error("counter loaded without counter use");
  AST_DONE_FLAG: assert property (@(posedge mclk) disable iff (srst)
    transfer_end |=> cpu_event_flags[2] && (buffer_status_update == $past(internal_end)))
    else $error("end of transfer did not set the done flag");
  AST_DIR_PICK: assert property (@(posedge mclk) disable iff (srst)
    ##1 (transfer_direction == $past(dma_setup[0])
      && list_buffer_pick == $past(dma_setup[1])))
    else $error("direction or buffer pick out of step with setup");
endmodule // hdt_transfer_ctrl

//--- rtl/hdt_pkg.sv
// constants shared by the host transfer control block
package hdt_pkg;
  // command codes of the microprocessor port
  localparam logic [7:0] CMD_SETUP_RD = 8'h21;
  localparam logic [7:0] CMD_SETUP_WR = 8'ha1;
  localparam logic [7:0] CMD_COUNT_RD = 8'h22;
  localparam logic [7:0] CMD_COUNT_WR = 8'ha2;
  localparam logic [7:0] CMD_FLAGS_RD = 8'h24;
  localparam logic [7:0] CMD_FLAGS_WR = 8'ha4;
  localparam logic [7:0] CMD_ENABLE_RD = 8'h25;
  localparam logic [7:0] CMD_ENABLE_WR = 8'ha5;
  // setup register fields
  localparam int SETUP_DIR_BIT = 0;
  localparam int SETUP_PICK_BIT = 1;
  localparam int SETUP_USE_BIT = 2;
  localparam int SETUP_RUN_BIT = 4;
  localparam int SETUP_BURST_LO = 5;
  localparam logic [15:0] SETUP_MASK = 16'h0077;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  // burst codes
  localparam logic [1:0] BURST_SINGLE = 2'h0;
  localparam logic [1:0] BURST_FOUR = 2'h1;
  localparam logic [1:0] BURST_EIGHT = 2'h2;
  localparam logic [1:0] BURST_RSVD = 2'h3;
  // byte count
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] BYTES_PER_BEAT = 16'h0002;
  // event flags: bit positions and writable mask
  localparam int EVT_ISO_BIT = 0;
  localparam int EVT_ASYNC_BIT = 1;
  localparam int EVT_DONE_BIT = 2;
  localparam int EVT_OPR_BIT = 4;
  localparam int EVT_SLEEP_BIT = 5;
  localparam int EVT_CLKRDY_BIT = 6;
  localparam logic [6:0] EVT_MASK = 7'h77;
  localparam logic [6:0] EVT_RESET = 7'h00;
  localparam logic [6:0] ENABLE_RESET = 7'h00;
  // transfer states
  typedef enum logic [2:0] {
    HDT_IDLE = 3'b001,
    HDT_REQ = 3'b010,
    HDT_GAP = 3'b100
  } hdt_state_e;
endpackage

//--- rtl/hdt_byte_counter.sv
// remaining-byte counter of a dma transfer
`timescale 1ns/1ps
module hdt_byte_counter (
  input wire logic mclk,
  input wire logic srst,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic beat,
  output logic [15:0] remaining,
  output logic last_beat
);
  wire logic [15:0] next_remaining;

  // last beat when no more than one word remains
  assign last_beat = (remaining <= hdt_pkg::BYTES_PER_BEAT);
  assign next_remaining = last_beat ? 16'h0000 : (remaining - hdt_pkg::BYTES_PER_BEAT);

  always_ff @(posedge mclk) begin
    if (srst) begin
      remaining <= hdt_pkg::COUNT_RESET;
    end else if (load) begin
      remaining <= load_value;
    end else if (beat) begin
      remaining <= next_remaining;
    end
  end

  AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (srst)
    (beat && !load && remaining > 16'h0002) |=> (remaining == $past(remaining) - 16'h0002))
    else $error("byte counter did not step by one word");
endmodule // hdt_byte_counter

//--- rtl/hdt_event_flags.sv
// sticky event flags, their enables and the interrupt level
`timescale 1ns/1ps
module hdt_event_flags (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [6:0] set_events,
  input wire logic flags_write,
  input wire logic enable_write,
  input wire logic [6:0] write_data,
  input wire logic irq_master_enable,
  output logic [6:0] flags,
  output logic [6:0] enables,
  output logic irq_out
);
  wire logic [6:0] clear_bits;
  wire logic [6:0] next_flags;
  wire logic irq_pending;

  // only a written one clears; set wins over clear
  assign clear_bits = flags_write ? (write_data & hdt_pkg::EVT_MASK) : 7'h00;
  assign next_flags = ((flags & ~clear_bits) | set_events) & hdt_pkg::EVT_MASK;
  // flag, enable and master enable all needed
  assign irq_pending = irq_master_enable && ((flags & enables) != 7'h00);

  // flag and enable storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      flags <= hdt_pkg::EVT_RESET;
      enables <= hdt_pkg::ENABLE_RESET;
      irq_out <= 1'b0;
    end else begin
      flags <= next_flags;
      if (enable_write) begin
        enables <= write_data & hdt_pkg::EVT_MASK;
      end
      irq_out <= irq_pending;
    end
  end

  AST_IRQ_GATED: assert property (@(posedge mclk) disable iff (srst)
    irq_out |-> $past(irq_master_enable) && (($past(flags) & $past(enables)) != 7'h00))
    else $error("interrupt raised without an enabled flag");
  AST_SET_WINS: assert property (@(posedge mclk) disable iff (srst)
    (set_events[2] && flags_write && write_data[2]) |=> flags[2])
    else $error("done event lost against a clear");
endmodule // hdt_event_flags

//--- verification/hdt_dma_partner.sv
// dma controller model answering the transfer request with beat acknowledges
`timescale 1ns/1ps
module hdt_dma_partner (
  input wire logic mclk,
  input wire logic srst,
  input wire logic dma_request_out,
  input wire logic slow,
  input wire logic [7:0] eot_beats,
  output logic dma_ack,
  output logic end_of_transfer
);
  logic [1:0] gap;
  logic [7:0] beats;
  // acknowledge beats, every cycle or with a three cycle pause
  always_ff @(posedge mclk) begin
    if (srst) begin
      dma_ack <= 1'b0;
      gap <= 2'h0;
      beats <= 8'h00;
    end else begin
      if (eot_beats == 8'h00) begin
        beats <= 8'h00;
      end else if (dma_request_out && dma_ack) begin
        beats <= beats + 8'h01;
      end
      if (dma_request_out && gap == 2'h0) begin
        dma_ack <= 1'b1;
        gap <= slow ? 2'h3 : 2'h0;
      end else begin
        dma_ack <= 1'b0;
        gap <= (gap != 2'h0) ? gap - 2'h1 : 2'h0;
      end
    end
  end
  assign end_of_transfer = (eot_beats != 8'h00) && (beats >= eot_beats);
endmodule // hdt_dma_partner

//--- verification/host_dma_transfer_control_tb.sv
// self-checking bench of the host dma transfer control block
`timescale 1ns/1ps
module host_dma_transfer_control_tb;
  logic mclk, srst, cmd_write, data_write, dma_ack, end_of_transfer, pio_done, master, slow;
  logic dma_request_out, list_buffer_pick, transfer_direction, buffer_status_update, irq_out;
  logic [7:0] cmd_code, eot_beats;
  logic [15:0] data_in, data_out;
  logic [4:0] ev;
  logic req_q;
  int miscompares, n_tests, n_beats, n_rises, n_bsu, bt, rs, bs;
  int exp_r [3] = '{10, 3, 2};

  hdt_transfer_ctrl i_hdt_transfer_ctrl (.mclk(mclk), .srst(srst), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .data_write(data_write), .data_in(data_in), .data_out(data_out),
    .dma_ack(dma_ack), .end_of_transfer(end_of_transfer), .pio_done(pio_done),
    .frame_iso_event(ev[0]), .async_list_event(ev[1]), .operational_event(ev[2]),
    .host_asleep_event(ev[3]), .clock_ready_event(ev[4]), .irq_master_enable(master),
    .dma_request_out(dma_request_out), .list_buffer_pick(list_buffer_pick),
    .transfer_direction(transfer_direction), .buffer_status_update(buffer_status_update),
    .irq_out(irq_out));
  hdt_dma_partner i_hdt_dma_partner (.mclk(mclk), .srst(srst),
    .dma_request_out(dma_request_out), .slow(slow), .eot_beats(eot_beats),
    .dma_ack(dma_ack), .end_of_transfer(end_of_transfer));

  // clock, 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // count beats, request rises and buffer status pulses
  always @(posedge mclk) begin
    if (!srst) begin
      n_beats += (dma_request_out && dma_ack);
      n_rises += (dma_request_out && !req_q);
      n_bsu += buffer_status_update;
    end
    req_q <= srst ? 1'b0 : dma_request_out;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    @(posedge mclk);
    cmd_write <= 1'b1;
    cmd_code <= code;
    @(posedge mclk);
    cmd_write <= 1'b0;
    data_write <= 1'b1;
    data_in <= d;
    @(posedge mclk);
    data_write <= 1'b0;
  endtask
  task automatic rd_raw(input logic [7:0] code);
    @(posedge mclk);
    cmd_write <= 1'b1;
    cmd_code <= code;
    @(posedge mclk);
    cmd_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    rd_raw(code);
    chk(data_out, exp);
  endtask
  // poll the flags until the done flag shows, bounded
  task automatic wait_done;
    int k;
    k = 0;
    rd_raw(8'h24);
    while (data_out[2] !== 1'b1 && k < 100) begin
      rd_raw(8'h24);
      k++;
    end
    if (data_out[2] !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: transfer never finished", $time);
    end
    repeat (2) @(posedge mclk);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    miscompares++;
    conclude();
  end

  initial begin
    {cmd_write, data_write, pio_done, master, slow} = 5'h00;
    {cmd_code, eot_beats, data_in, ev} = 37'h0;
    srst = 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk({12'h0, dma_request_out, irq_out, list_buffer_pick, transfer_direction}, 16'h0);
    rd(8'h21, 16'h0000);
    rd(8'h22, 16'h0000);
    rd(8'h24, 16'h0000);
    rd(8'h25, 16'h0000);
    rd(8'h30, 16'h0000);
    $display("test reset values done");
    wr(8'ha2, 16'h1234);
    rd(8'h22, 16'h1234);
    wr(8'ha1, 16'hffff);
    repeat (8) @(posedge mclk);
    chk({14'h0, list_buffer_pick, transfer_direction}, 16'h0003);
    chk({15'h0, dma_request_out}, 16'h0);
    rd(8'h21, 16'h0077);
    wr(8'ha1, 16'h0000);
    rd(8'h21, 16'h0000);
    chk({14'h0, list_buffer_pick, transfer_direction}, 16'h0);
    $display("test setup fields done");
    for (int b = 0; b < 3; b++) begin
      bt = n_beats;
      rs = n_rises;
      bs = n_bsu;
      slow <= (b == 2);
      wr(8'ha2, 16'h0014);
      wr(8'ha1, {9'h0, b[1:0], 5'h17});
      wait_done();
      chk(16'(n_beats - bt), 16'd10);
      chk(16'(n_rises - rs), 16'(exp_r[b]));
      chk(16'(n_bsu - bs), 16'd1);
      rd(8'h21, {9'h0, b[1:0], 5'h07});
      rd(8'h24, 16'h0004);
      rd(8'h24, 16'h0004);
      wr(8'ha4, 16'h00ff);
      rd(8'h24, 16'h0000);
    end
    $display("test burst transfers done");
    slow <= 1'b0;
    wr(8'ha2, 16'h0000);
    wr(8'ha1, 16'h0014);
    repeat (10) @(posedge mclk);
    chk({15'h0, dma_request_out}, 16'h0);
    rd(8'h21, 16'h0014);
    bs = n_bsu;
    eot_beats <= 8'h03;
    wr(8'ha1, 16'h0010);
    wait_done();
    eot_beats <= 8'h00;
    rd(8'h21, 16'h0000);
    chk(16'(n_bsu - bs), 16'd0);
    wr(8'ha4, 16'h00ff);
    $display("test zero count and external end done");
    wr(8'ha5, 16'h0004);
    @(posedge mclk);
    pio_done <= 1'b1;
    @(posedge mclk);
    pio_done <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({15'h0, irq_out}, 16'h0);
    master <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({15'h0, irq_out}, 16'h1);
    wr(8'ha4, 16'h0004);
    repeat (3) @(posedge mclk);
    chk({15'h0, irq_out}, 16'h0);
    @(posedge mclk);
    ev <= 5'h1f;
    @(posedge mclk);
    ev <= 5'h00;
    rd(8'h24, 16'h0073);
    rd(8'h24, 16'h0073);
    chk({15'h0, irq_out}, 16'h0);
    wr(8'ha4, 16'h0001);
    rd(8'h24, 16'h0072);
    wr(8'ha4, 16'h00ff);
    rd(8'h24, 16'h0000);
    $display("test event flags done");
    conclude();
  end
endmodule // host_dma_transfer_control_tb
